// File: include/qio_pkg.sv
// Package: constants and types for the quad channel mode control block
package qio_pkg;

  localparam int NUM_CH = 4;

  // Output mode field codes
  localparam logic [1:0] MODE_HS       = 2'h0;
  localparam logic [1:0] MODE_HS_SURGE = 2'h1;
  localparam logic [1:0] MODE_PP_CLAMP = 2'h2;
  localparam logic [1:0] MODE_PP       = 2'h3;

  // Limit select codes
  localparam logic [1:0] LIM_600MA  = 2'h0;
  localparam logic [1:0] LIM_130MA  = 2'h1;
  localparam logic [1:0] LIM_300MA  = 2'h2;
  localparam logic [1:0] LIM_1200MA = 2'h3;

  // Current limits in mA
  localparam logic [11:0] CUR_600MA  = 12'h258;
  localparam logic [11:0] CUR_130MA  = 12'h082;
  localparam logic [11:0] CUR_300MA  = 12'h12c;
  localparam logic [11:0] CUR_1200MA = 12'h4b0;

  // Reset values
  localparam logic [3:0] INPUT_SEL_RST = 4'h0;
  localparam logic       TYPE_SEL_RST  = 1'b0;

  // Surge windows in ms and their cycle counts at the clock rate
  localparam int CLK_HZ       = 200_000_000;
  localparam int SURGE_MS_00  = 20;
  localparam int SURGE_MS_01  = 50;
  localparam int SURGE_MS_10  = 40;
  localparam int SURGE_MS_11  = 10;
  localparam int CYC_PER_MS   = CLK_HZ / 1000;
  localparam int SURGE_CYC_00 = SURGE_MS_00 * CYC_PER_MS;
  localparam int SURGE_CYC_01 = SURGE_MS_01 * CYC_PER_MS;
  localparam int SURGE_CYC_10 = SURGE_MS_10 * CYC_PER_MS;
  localparam int SURGE_CYC_11 = SURGE_MS_11 * CYC_PER_MS;
  localparam int SURGE_CNT_W  = 24;

  // Channel operating state
  typedef enum logic [2:0] {
    CH_HS,
    CH_HS_SURGE,
    CH_PP_CLAMP,
    CH_PP,
    CH_HIZ,
    CH_DI
  } ch_mode_t;

endpackage

// File: hw/surge_timer.sv
// Per-channel surge window timer
`timescale 1ns/1ps
`default_nettype none
module surge_timer #(
  parameter int CNT_W = 24
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rstN,
  // Control
  input  wire logic             start,
  input  wire logic             hold,
  input  wire logic [CNT_W-1:0] length,
  // Status
  output logic                  active
);
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;
  logic             act_q;
  logic             act_d;

  // Load on start, count down while held on
  always_comb begin
    cnt_d = cnt_q;
    act_d = act_q;
    if (!hold) begin
      act_d = 1'b0;
      cnt_d = '0;
    end else if (start) begin
      act_d = 1'b1;
      cnt_d = length;
    end else if (act_q) begin
      if (cnt_q <= CNT_W'(1)) begin
        act_d = 1'b0;
        cnt_d = '0;
      end else begin
        cnt_d = cnt_q - CNT_W'(1);
      end
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      cnt_q <= '0;
      act_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      act_q <= act_d;
    end
  end

  assign active = act_q;
endmodule
`default_nettype wire

// File: hw/thermal_guard.sv
// Per-channel thermal shutdown with hysteresis
`timescale 1ns/1ps
`default_nettype none
module thermal_guard (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rstN,
  // Sensor comparators
  input  wire logic overTemp,
  input  wire logic coolEnough,
  // Status
  output logic      shutdown,
  output logic      tripPulse
);
  logic sd_q;
  logic sd_d;
  logic trip_q;
  logic trip_d;

  // Trip above threshold, release after hysteresis drop
  always_comb begin
    sd_d   = sd_q;
    trip_d = 1'b0;
    if (!sd_q && overTemp) begin
      sd_d   = 1'b1;
      trip_d = 1'b1;
    end else if (sd_q && coolEnough && !overTemp) begin
      sd_d = 1'b0;
    end
  end

  // State registers
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      sd_q   <= 1'b0;
      trip_q <= 1'b0;
    end else begin
      sd_q   <= sd_d;
      trip_q <= trip_d;
    end
  end

  assign shutdown  = sd_q;
  assign tripPulse = trip_q;
endmodule
`default_nettype wire

// File: hw/quad_channel_io_mode_control.sv
// Top: per-channel direction, mode, drive, readback and overload logic
//
// How it works
// - input_select bit 0 output, 1 input
// - all channels are outputs after reset
// - decode four output modes from mode field
// - input: upper bit 1 high-Z, else digital input
// - one global input type bit, reset Type 1/3
// - input levels go to readback and pins
// - high-side drives high when on, else high-Z
// - pin gate high ORs level bit with pin
// - output readback shows terminal level, not pins
// - source select 1 shows supply fault latches
// - gate drive pin only when its enable set
// - enable low tri-states high-side, low-side and clamp drivers; gate drive pins and input sinks stay on
// - limit select picks high-side current limit
// - inrush mode doubles limit for surge window
// - limit flag set while current limiting
// - thermal trip forces driver high-Z until cool
// - thermal trip sets channel thermal flag
// - thermal trip sets event; fault when unmasked
`timescale 1ns/1ps
`default_nettype none
module quad_channel_io_mode_control #(
  parameter int NCH          = qio_pkg::NUM_CH,
  parameter int SURGE_CYC_00 = qio_pkg::SURGE_CYC_00,
  parameter int SURGE_CYC_01 = qio_pkg::SURGE_CYC_01,
  parameter int SURGE_CYC_10 = qio_pkg::SURGE_CYC_10,
  parameter int SURGE_CYC_11 = qio_pkg::SURGE_CYC_11
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  // Channel configuration
  input  wire logic [NCH-1:0]   inputSelect,
  input  wire logic [2*NCH-1:0] outputModeField,
  input  wire logic             inputTypeSelect,
  input  wire logic [NCH-1:0]   outputLevelBit,
  input  wire logic [2*NCH-1:0] limitSelect,
  input  wire logic [NCH-1:0]   gateDriveEnable,
  input  wire logic             readbackSourceSelect,
  input  wire logic             overloadMask,
  // Fault clears from the host
  input  wire logic [NCH-1:0]   supplyFaultClear,
  input  wire logic [NCH-1:0]   limitFlagClear,
  input  wire logic [NCH-1:0]   thermalFlagClear,
  input  wire logic             overloadEventClear,
  // Direct pins
  input  wire logic             directPinGate,
  input  wire logic             driverEnable,
  input  wire logic [NCH-1:0]   directIoIn,
  output logic      [NCH-1:0]   directIoOut,
  output logic      [NCH-1:0]   directIoOe,
  // Analog front-end sense
  input  wire logic [NCH-1:0]   terminalSense,
  input  wire logic [NCH-1:0]   inLimiting,
  input  wire logic [NCH-1:0]   overTemp,
  input  wire logic [NCH-1:0]   coolEnough,
  input  wire logic [NCH-1:0]   supplyLow,
  // Driver controls
  output logic      [NCH-1:0]   highSideOn,
  output logic      [NCH-1:0]   lowSideOn,
  output logic      [NCH-1:0]   activeClamp,
  output logic      [NCH-1:0]   lowLeakHiZ,
  output logic      [NCH-1:0]   sinkEnable,
  output logic                  sinkType2,
  output logic      [NCH-1:0]   gateDrivePin,
  output logic      [12*NCH-1:0] currentLimitMa,
  // Status
  output logic      [NCH-1:0]   levelReadback,
  output logic      [NCH-1:0]   limitFlag,
  output logic      [NCH-1:0]   thermalFlag,
  output logic                  overloadEvent,
  output logic                  fault_out_n
);
  import qio_pkg::*;

  // Reset release through two flops
  logic rstSync1_q;
  logic rstSync2_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1_q <= 1'b0;
      rstSync2_q <= 1'b0;
    end else begin
      rstSync1_q <= 1'b1;
      rstSync2_q <= rstSync1_q;
    end
  end
  logic rstN;
  assign rstN = rstSync2_q;

  // Per-channel combinational results
  logic [NCH-1:0]    hsOn;
  logic [NCH-1:0]    lsOn;
  logic [NCH-1:0]    clampOn;
  logic [NCH-1:0]    hizOn;
  logic [NCH-1:0]    sinkOn;
  logic [NCH-1:0]    gateOn;
  logic [NCH-1:0]    pinOut;
  logic [NCH-1:0]    pinOe;
  logic [NCH-1:0]    readback;
  logic [NCH-1:0]    thermSd;
  logic [NCH-1:0]    thermTrip;
  logic [NCH-1:0]    surgeAct;
  logic [NCH-1:0]    levelNow;
  logic [12*NCH-1:0] limitMa;

  // Registered state
  logic [NCH-1:0] levelPrev_q;
  logic [NCH-1:0] supplyFault_q;
  logic [NCH-1:0] supplyFault_d;
  logic [NCH-1:0] limFlag_q;
  logic [NCH-1:0] limFlag_d;
  logic [NCH-1:0] thFlag_q;
  logic [NCH-1:0] thFlag_d;
  logic           ovlEvent_q;
  logic           ovlEvent_d;

  // Next values of the registered outputs
  logic [NCH-1:0]    highSideOn_d;
  logic [NCH-1:0]    lowSideOn_d;
  logic [NCH-1:0]    activeClamp_d;
  logic [NCH-1:0]    lowLeakHiZ_d;
  logic [NCH-1:0]    sinkEnable_d;
  logic              sinkType2_d;
  logic [NCH-1:0]    gateDrivePin_d;
  logic [12*NCH-1:0] currentLimitMa_d;
  logic [NCH-1:0]    directIoOut_d;
  logic [NCH-1:0]    directIoOe_d;
  logic [NCH-1:0]    levelReadback_d;
  logic [NCH-1:0]    limitFlag_d;
  logic [NCH-1:0]    thermalFlag_d;
  logic              overloadEvent_d;
  logic              faultOutN_d;
  logic [NCH-1:0]    levelPrev_d;

  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      logic [1:0]             mode;
      logic [1:0]             lim;
      ch_mode_t               chMode;
      logic [11:0]            baseMa;
      logic [SURGE_CNT_W-1:0] surgeLen;

      assign mode = outputModeField[2*ch +: 2];
      assign lim  = limitSelect[2*ch +: 2];

      // Direction and mode decode
      always_comb begin
        if (!inputSelect[ch]) begin
          unique case (mode)
            MODE_HS:       chMode = CH_HS;
            MODE_HS_SURGE: chMode = CH_HS_SURGE;
            MODE_PP_CLAMP: chMode = CH_PP_CLAMP;
            MODE_PP:       chMode = CH_PP;
          endcase
        end else if (mode[1]) begin
          chMode = CH_HIZ;
        end else begin
          chMode = CH_DI;
        end
      end

      // Level merge: register bit ORed with pin under gate
      assign levelNow[ch] = outputLevelBit[ch] | (directPinGate & directIoIn[ch]);

      // Output stage control, enable and thermal override
      always_comb begin
        hsOn[ch]    = 1'b0;
        lsOn[ch]    = 1'b0;
        clampOn[ch] = 1'b0;
        hizOn[ch]   = 1'b0;
        sinkOn[ch]  = 1'b0;
        unique case (chMode)
          CH_HS, CH_HS_SURGE: hsOn[ch] = levelNow[ch];
          CH_PP_CLAMP: begin
            hsOn[ch]    = levelNow[ch];
            lsOn[ch]    = ~levelNow[ch];
            clampOn[ch] = 1'b1;
          end
          CH_PP: begin
            hsOn[ch] = levelNow[ch];
            lsOn[ch] = ~levelNow[ch];
          end
          CH_HIZ: hizOn[ch] = 1'b1;
          CH_DI:  sinkOn[ch] = 1'b1;
        endcase
        if (!driverEnable || thermSd[ch]) begin
          hsOn[ch]    = 1'b0;
          lsOn[ch]    = 1'b0;
          clampOn[ch] = 1'b0;
        end
      end

      // Current limit select and surge doubling
      always_comb begin
        unique case (lim)
          LIM_600MA: begin
            baseMa   = CUR_600MA;
            surgeLen = SURGE_CNT_W'(SURGE_CYC_00);
          end
          LIM_130MA: begin
            baseMa   = CUR_130MA;
            surgeLen = SURGE_CNT_W'(SURGE_CYC_01);
          end
          LIM_300MA: begin
            baseMa   = CUR_300MA;
            surgeLen = SURGE_CNT_W'(SURGE_CYC_10);
          end
          LIM_1200MA: begin
            baseMa   = CUR_1200MA;
            surgeLen = SURGE_CNT_W'(SURGE_CYC_11);
          end
        endcase
      end
      assign limitMa[12*ch +: 12] = surgeAct[ch] ? {baseMa[10:0], 1'b0} : baseMa;

      // Surge window starts on each switch-on in inrush mode
      surge_timer #(
        .CNT_W (SURGE_CNT_W)
      ) u_surge (
        .clk    (ref_clk),
        .rstN   (rstN),
        .start  (hsOn[ch] & ~levelPrev_q[ch]),
        .hold   (chMode == CH_HS_SURGE && hsOn[ch]),
        .length (surgeLen),
        .active (surgeAct[ch])
      );

      // Thermal shutdown with hysteresis
      thermal_guard u_therm (
        .clk        (ref_clk),
        .rstN       (rstN),
        .overTemp   (overTemp[ch]),
        .coolEnough (coolEnough[ch]),
        .shutdown   (thermSd[ch]),
        .tripPulse  (thermTrip[ch])
      );

      // Gate drive, direct pin direction and readback source
      assign gateOn[ch]   = gateDriveEnable[ch];
      assign pinOe[ch]    = inputSelect[ch];
      assign pinOut[ch]   = inputSelect[ch] & terminalSense[ch];
      assign readback[ch] = readbackSourceSelect ? supplyFault_q[ch]
                                                 : terminalSense[ch];
    end
  endgenerate

  // Sticky flags: set wins over clear
  always_comb begin
    supplyFault_d = (supplyFault_q & ~supplyFaultClear)
                  | (supplyLow & {NCH{readbackSourceSelect}});
    limFlag_d     = (limFlag_q & ~limitFlagClear) | inLimiting;
    thFlag_d      = (thFlag_q & ~thermalFlagClear) | thermTrip;
    ovlEvent_d    = (ovlEvent_q & ~overloadEventClear) | (|thermTrip);
  end

  // Output next values, all registered below
  always_comb begin
    highSideOn_d     = hsOn;
    lowSideOn_d      = lsOn;
    activeClamp_d    = clampOn;
    lowLeakHiZ_d     = hizOn;
    sinkEnable_d     = sinkOn;
    sinkType2_d      = inputTypeSelect;
    gateDrivePin_d   = gateOn;
    currentLimitMa_d = limitMa;
    directIoOut_d    = pinOut;
    directIoOe_d     = pinOe;
    levelReadback_d  = readback;
    limitFlag_d      = limFlag_d;
    thermalFlag_d    = thFlag_d;
    overloadEvent_d  = ovlEvent_d;
    faultOutN_d      = ~(ovlEvent_d & ~overloadMask);
    // Previous high-side state for the surge start edge
    levelPrev_d      = hsOn;
  end

  // Flag registers
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      supplyFault_q <= '0;
      limFlag_q     <= '0;
      thFlag_q      <= '0;
      ovlEvent_q    <= 1'b0;
      levelPrev_q   <= '0;
    end else begin
      supplyFault_q <= supplyFault_d;
      limFlag_q     <= limFlag_d;
      thFlag_q      <= thFlag_d;
      ovlEvent_q    <= ovlEvent_d;
      levelPrev_q   <= levelPrev_d;
    end
  end

  // Registered outputs
  always_ff @(posedge ref_clk or negedge rstN) begin
    if (!rstN) begin
      highSideOn     <= '0;
      lowSideOn      <= '0;
      activeClamp    <= '0;
      lowLeakHiZ     <= '0;
      sinkEnable     <= '0;
      sinkType2      <= TYPE_SEL_RST;
      gateDrivePin   <= '0;
      currentLimitMa <= '0;
      directIoOut    <= '0;
      directIoOe     <= '0;
      levelReadback  <= '0;
      limitFlag      <= '0;
      thermalFlag    <= '0;
      overloadEvent  <= 1'b0;
      fault_out_n    <= 1'b1;
    end else begin
      highSideOn     <= highSideOn_d;
      lowSideOn      <= lowSideOn_d;
      activeClamp    <= activeClamp_d;
      lowLeakHiZ     <= lowLeakHiZ_d;
      sinkEnable     <= sinkEnable_d;
      sinkType2      <= sinkType2_d;
      gateDrivePin   <= gateDrivePin_d;
      currentLimitMa <= currentLimitMa_d;
      directIoOut    <= directIoOut_d;
      directIoOe     <= directIoOe_d;
      levelReadback  <= levelReadback_d;
      limitFlag      <= limitFlag_d;
      thermalFlag    <= thermalFlag_d;
      overloadEvent  <= overloadEvent_d;
      fault_out_n    <= faultOutN_d;
    end
  end
endmodule
`default_nettype wire

// File: verif/qio_mode_chk.sv
// Checker: port-level timing relations of the mode control block
`timescale 1ns/1ps
`default_nettype none
module qio_mode_chk (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Configuration and sense
  input wire logic [3:0] inputSelect,
  input wire logic [7:0] outputModeField,
  input wire logic [3:0] outputLevelBit,
  input wire logic       driverEnable,
  input wire logic [3:0] overTemp,
  input wire logic [3:0] coolEnough,
  input wire logic [3:0] gateDriveEnable,
  input wire logic       overloadMask,
  // Design outputs
  input wire logic [3:0] highSideOn,
  input wire logic [3:0] lowSideOn,
  input wire logic [3:0] directIoOe,
  input wire logic [3:0] gateDrivePin,
  input wire logic [3:0] thermalFlag,
  input wire logic       overloadEvent,
  input wire logic       fault_out_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // Channel 0 high-side request, cool and enabled
  wire hsCond = driverEnable && !inputSelect[0] && outputModeField[1:0] == 2'h0
    && outputLevelBit[0] && !overTemp[0] && coolEnough[0];
  // Output relations
  drv_off_a: assert property (!driverEnable |=> !highSideOn && !lowSideOn)
    else $error("driver on while disabled");
  hs_on_a: assert property (hsCond [*4] |=> highSideOn[0])
    else $error("high side not on");
  in_quiet_a: assert property (inputSelect[1] [*2] |-> !highSideOn[1] && !lowSideOn[1])
    else $error("input channel drives");
  dir_oe_a: assert property ($stable(inputSelect) [*4] |=> directIoOe == $past(inputSelect))
    else $error("pin direction wrong");
  hot_off_a: assert property (overTemp[0] [*3] |-> !highSideOn[0] && !lowSideOn[0])
    else $error("driver on while hot");
  trip_flag_a: assert property ($rose(overTemp[0]) |-> ##[1:3] thermalFlag[0] && overloadEvent)
    else $error("thermal flags not set");
  fault_on_a: assert property ((overloadEvent && !overloadMask) [*2] |-> !fault_out_n)
    else $error("fault not asserted");
  fault_mask_a: assert property (overloadMask [*2] |-> fault_out_n)
    else $error("masked fault asserted");
  gate_pin_a: assert property ($stable(gateDriveEnable) [*4] |=> gateDrivePin == $past(gateDriveEnable))
    else $error("gate drive mismatch");
endmodule
`default_nettype wire

// File: verif/host_pin_model.sv
// Host-side model of the direct logic pins
`timescale 1ns/1ps
`default_nettype none
module host_pin_model (
  // Device side
  input  wire logic [3:0] dioOut,
  input  wire logic [3:0] dioOe,
  // Host side
  input  wire logic [3:0] hostVal,
  input  wire logic [3:0] hostOe,
  output logic      [3:0] pinLevel
);
  // Pin level: device, else host, else pull-down
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      if (dioOe[i]) pinLevel[i] = dioOut[i];
      else if (hostOe[i]) pinLevel[i] = hostVal[i];
      else pinLevel[i] = 1'b0;
    end
  end
endmodule
`default_nettype wire

// File: verif/quad_channel_io_mode_control_test.sv
// Testbench top: scenarios for the mode control block
`timescale 1ns/1ps
`default_nettype none
module quad_channel_io_mode_control_test;
  import qio_pkg::*;
  logic       ref_clk = 1'b0, rst_n = 1'b0, inputTypeSelect = 1'b0;
  logic       readbackSourceSelect = 1'b0, overloadMask = 1'b0, overloadEventClear = 1'b0;
  logic       directPinGate = 1'b0, driverEnable = 1'b1;
  logic [3:0] inputSelect = 4'h0, outputLevelBit = 4'h0, gateDriveEnable = 4'h0;
  logic [3:0] supplyFaultClear = 4'h0, limitFlagClear = 4'h0, thermalFlagClear = 4'h0;
  logic [3:0] terminalSense = 4'h0, inLimiting = 4'h0, overTemp = 4'h0;
  logic [3:0] coolEnough = 4'hf, supplyLow = 4'h0, hostVal = 4'h0, hostOe = 4'h0;
  logic [7:0] outputModeField = 8'h0, limitSelect = 8'h0;
  wire  [3:0] directIoIn, directIoOut, directIoOe, highSideOn, lowSideOn, activeClamp;
  wire  [3:0] lowLeakHiZ, sinkEnable, gateDrivePin, levelReadback, limitFlag, thermalFlag;
  wire        sinkType2, overloadEvent, fault_out_n;
  wire [47:0] currentLimitMa;
  int         bad_count = 0, cmp_count = 0;
  // Clock, device and host pins
  always #2.5 ref_clk = ~ref_clk;
  quad_channel_io_mode_control #(.SURGE_CYC_00(12), .SURGE_CYC_01(30), .SURGE_CYC_10(24),
    .SURGE_CYC_11(6)) u_quad_channel_io_mode_control (.*);
  host_pin_model u_host_pin_model (.dioOut(directIoOut), .dioOe(directIoOe),
    .hostVal(hostVal), .hostOe(hostOe), .pinLevel(directIoIn));
  // Helpers
  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp, input string m);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask
  task automatic stop_test();
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Scenarios
  task automatic t_reset();
    chk(directIoOe, 4'h0, "outputs after reset");
    chk({sinkType2, fault_out_n}, 2'h1, "type and fault after reset");
  endtask
  task automatic t_modes();
    outputLevelBit = 4'h1;
    for (int m = 0; m < 4; m++) begin
      outputModeField = 8'(m);
      cyc(3);
      chk({highSideOn[0], activeClamp[0]}, {1'b1, m == 2}, "mode decode");
    end
    outputLevelBit = 4'h0;
    cyc(3);
    chk(lowSideOn[0], 1'b1, "push-pull low");
    outputModeField = 8'h0;
    cyc(3);
    chk({highSideOn[0], lowSideOn[0]}, 2'h0, "high side off");
  endtask
  task automatic t_surge();
    int          win [4] = '{12, 30, 24, 6};
    logic [11:0] base [4] = '{CUR_600MA, CUR_130MA, CUR_300MA, CUR_1200MA};
    outputModeField = 8'h1;
    for (int c = 0; c < 4; c++) begin
      limitSelect = 8'(c);
      cyc(3);
      chk(currentLimitMa[11:0], base[c], "limit");
      outputLevelBit = 4'h1;
      cyc(3);
      chk(currentLimitMa[11:0], base[c] * 2, "doubled");
      cyc(win[c] + 4);
      chk(currentLimitMa[11:0], base[c], "window end");
      outputLevelBit = 4'h0;
    end
    outputModeField = 8'h0;
  endtask
  task automatic t_input();
    inputSelect = 4'h2;
    terminalSense = 4'h6;
    cyc(3);
    chk({directIoOe, directIoIn[1]}, 5'h5, "input pin");
    chk(levelReadback, 4'h6, "readback");
    chk({sinkEnable[1], lowLeakHiZ[1]}, 2'h2, "digital input");
    inputTypeSelect = 1'b1;
    outputModeField = 8'h8;
    cyc(3);
    chk({sinkType2, sinkEnable[1], lowLeakHiZ[1]}, 3'h5, "type 2, hi-Z");
    inputSelect = 4'h0;
    inputTypeSelect = 1'b0;
    outputModeField = 8'h0;
    terminalSense = 4'h0;
  endtask
  task automatic t_pins();
    directPinGate = 1'b1;
    hostOe = 4'h1;
    hostVal = 4'h1;
    gateDriveEnable = 4'h8;
    cyc(3);
    chk({highSideOn[0], gateDrivePin}, 5'h18, "pin OR, gate drive");
    driverEnable = 1'b0;
    cyc(3);
    chk(highSideOn, 4'h0, "disabled");
    driverEnable = 1'b1;
    directPinGate = 1'b0;
    hostOe = 4'h0;
    gateDriveEnable = 4'h0;
  endtask
  task automatic t_flags();
    readbackSourceSelect = 1'b1;
    supplyLow = 4'h8;
    inLimiting = 4'h4;
    cyc(2);
    supplyLow = 4'h0;
    inLimiting = 4'h0;
    cyc(3);
    chk({levelReadback[3], limitFlag[2]}, 2'h3, "latched");
    supplyFaultClear = 4'h8;
    limitFlagClear = 4'h4;
    cyc(1);
    supplyFaultClear = 4'h0;
    limitFlagClear = 4'h0;
    cyc(3);
    chk({levelReadback[3], limitFlag[2]}, 2'h0, "cleared");
    readbackSourceSelect = 1'b0;
  endtask
  task automatic t_thermal();
    outputLevelBit = 4'h1;
    cyc(3);
    overTemp = 4'h1;
    coolEnough = 4'h0;
    cyc(3);
    chk({highSideOn[0], thermalFlag[0], overloadEvent, fault_out_n}, 4'h6, "trip");
    overTemp = 4'h0;
    coolEnough = 4'hf;
    cyc(3);
    chk(highSideOn[0], 1'b1, "resumed");
    thermalFlagClear = 4'h1;
    overloadEventClear = 1'b1;
    overloadMask = 1'b1;
    cyc(1);
    thermalFlagClear = 4'h0;
    overloadEventClear = 1'b0;
    overTemp = 4'h1;
    coolEnough = 4'he;
    cyc(3);
    chk({overloadEvent, fault_out_n}, 2'h3, "masked");
    overTemp = 4'h0;
    coolEnough = 4'hf;
    outputLevelBit = 4'h0;
  endtask
  // Main sequence
  initial begin
    cyc(12);
    rst_n = 1'b1;
    cyc(4);
    t_reset();
    t_modes();
    t_surge();
    t_input();
    t_pins();
    t_flags();
    t_thermal();
    stop_test();
  end
  // Watchdog
  initial begin
    #20us;
    bad_count++;
    stop_test();
  end
endmodule
bind quad_channel_io_mode_control qio_mode_chk u_qio_mode_chk (.*);
`default_nettype wire
